// File: ltpg_core.sv
// Contract
// - pattern code in control bits three to zero
// - two control bits pick injection point
// - inject at sample, symbol or octet input
// - code 0011: 31-bit generator, given seed
// - code 0100: 23-bit generator, given seed
// - codes 0101-0111: 15, 9, 7 bit generators
// - code 1000: ramp wrapping at word width
// - code 1110: user words one-four, repeating
// - code 1111: user words once, then zeros
// - sample input: one word per frame
// - symbol input: ten-bit words, user bits 15:6
// - octet input: eight-bit words, upper user bits
// - user words from writable byte registers
// - three-bit link layer test field
`timescale 1ns/1ps
`default_nettype none
module ltpg_core
  import ltpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_tick,
  input wire logic symbol_tick,
  input wire logic octet_tick,
  input wire logic [15:0] sample_in,
  input wire logic [9:0] symbol_in,
  input wire logic [7:0] octet_in,
  output logic [15:0] sample_out,
  output logic [9:0] symbol_out,
  output logic [7:0] octet_out,
  output logic test_active,
  output logic [2:0] link_layer_test_mode,
  output logic [1:0] sync_pair_disable
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // word width of an injection point
  function automatic logic [4:0] inj_width(input logic [1:0] inj);
    case (inj)
      INJ_SYMBOL: inj_width = WIDTH_SYMBOL;
      INJ_OCTET: inj_width = WIDTH_OCTET;
      default: inj_width = WIDTH_SAMPLE;
    endcase
  endfunction

  // low-bit mask for a word width
  function automatic logic [15:0] width_mask(input logic [4:0] w);
    logic [16:0] m;
    m = (17'h00001 << w) - 17'h00001;
    width_mask = m[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register file state
  logic [7:0] user_byte_reg [0:7]; // user pattern bytes, low byte first
  logic [7:0] user_byte_next [0:7];
  logic [7:0] link_ctrl_reg; // link control byte
  logic [7:0] link_ctrl_next;
  logic [7:0] pat_ctrl_reg; // pattern code and injection point
  logic [7:0] pat_ctrl_next;
  logic [7:0] layer_ctrl_reg; // link layer test code
  logic [7:0] layer_ctrl_next;
  // axi slave state
  logic aw_full_reg, aw_full_next; // write address held
  logic [13:0] aw_idx_reg, aw_idx_next;
  logic w_full_reg, w_full_next; // write data held
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next; // byte lane zero enabled
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // pattern engine state
  logic [3:0] mode_prev_reg, mode_prev_next; // code seen last cycle
  logic [1:0] inj_prev_reg, inj_prev_next; // injection seen last cycle
  logic [30:0] lfsr_reg, lfsr_next; // pseudo-random generator
  logic [15:0] ramp_reg, ramp_next; // ramp counter
  logic phase_reg, phase_next; // checkerboard and toggle phase
  ltpg_user_e usr_reg, usr_next; // user word sequencer
  logic [15:0] sample_reg, sample_next;
  logic [9:0] symbol_reg, symbol_next;
  logic [7:0] octet_reg, octet_next;

  // decoded controls
  logic [3:0] mode; // selected pattern code
  logic [1:0] inj; // selected injection point
  logic [4:0] width; // word width at injection point
  logic active; // a pattern replaces data
  logic restart; // pattern newly selected
  logic tick; // selected point takes a word
  logic [4:0] pn_len, pn_tap;
  logic [30:0] pn_seed, pn_state;
  logic [15:0] pn_word;
  logic [15:0] user_word; // current 16-bit user word
  logic [15:0] pat_word; // pattern word, low width bits valid
  logic aw_hs, w_hs, ar_hs, do_write;
  logic [13:0] ar_idx;

  ////////////////////////////////////////////////////////////////////////////////
  // control decode
  always_comb begin
    mode = pat_ctrl_reg[MODE_LSB +: 4];
    inj = pat_ctrl_reg[INJ_LSB +: 2];
    width = inj_width(inj);
    active = (mode != MODE_OFF) && (inj != INJ_NONE);
    restart = (mode != mode_prev_reg) || (inj != inj_prev_reg);
    // one step per word at the chosen point
    case (inj)
      INJ_SAMPLE: tick = frame_tick;
      INJ_SYMBOL: tick = symbol_tick;
      INJ_OCTET: tick = octet_tick;
      default: tick = 1'b0;
    endcase
  end

  // generator length, tap and seed per code
  always_comb begin
    case (mode)
      MODE_PN31: begin
        pn_len = LEN_PN31;
        pn_tap = TAP_PN31;
        pn_seed = SEED_PN31;
      end
      MODE_PN23: begin
        pn_len = LEN_PN23;
        pn_tap = TAP_PN23;
        pn_seed = SEED_PN23;
      end
      MODE_PN15: begin
        pn_len = LEN_PN15;
        pn_tap = TAP_PN15;
        pn_seed = SEED_PN15;
      end
      MODE_PN9: begin
        pn_len = LEN_PN9;
        pn_tap = TAP_PN9;
        pn_seed = SEED_PN9;
      end
      default: begin
        pn_len = LEN_PN7;
        pn_tap = TAP_PN7;
        pn_seed = SEED_PN7;
      end
    endcase
  end

  // generator word and its successor state
  ltpg_prbs_step u_prbs (
    .state_in(lfsr_reg),
    .len(pn_len),
    .tap(pn_tap),
    .width(width),
    .state_out(pn_state),
    .word(pn_word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pattern word selection
  always_comb begin
    // user word n is byte 2n-1 low, byte 2n high
    user_word = {user_byte_reg[{usr_reg[1:0], 1'b1}], user_byte_reg[{usr_reg[1:0], 1'b0}]};
    case (mode)
      MODE_CHECKER: pat_word = phase_reg ? CHECKER_ODD : CHECKER_EVEN;
      MODE_TOGGLE: pat_word = phase_reg ? TOGGLE_ODD : TOGGLE_EVEN;
      MODE_PN31, MODE_PN23, MODE_PN15, MODE_PN9, MODE_PN7: pat_word = pn_word;
      MODE_RAMP: pat_word = ramp_reg;
      MODE_USER_REPEAT, MODE_USER_SINGLE: begin
        // most significant bits of the user word
        if (usr_reg == USR_ZERO) begin
          pat_word = WORD_ZERO;
        end else begin
          pat_word = user_word >> (WIDTH_SAMPLE - width);
        end
      end
      default: pat_word = WORD_ZERO;
    endcase
    pat_word = pat_word & width_mask(width);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pattern engine next state
  always_comb begin
    mode_prev_next = mode;
    inj_prev_next = inj;
    lfsr_next = lfsr_reg;
    ramp_next = ramp_reg;
    phase_next = phase_reg;
    usr_next = usr_reg;
    if (restart) begin
      // fresh selection starts from seed, zero and word one
      lfsr_next = pn_seed;
      ramp_next = WORD_ZERO;
      phase_next = 1'b0;
      usr_next = USR_W1;
    end else if (active && tick) begin
      lfsr_next = pn_state;
      ramp_next = (ramp_reg + RAMP_STEP) & width_mask(width);
      phase_next = ~phase_reg;
      case (usr_reg)
        USR_W1: usr_next = USR_W2;
        USR_W2: usr_next = USR_W3;
        USR_W3: usr_next = USR_W4;
        USR_W4: usr_next = (mode == MODE_USER_SINGLE) ? USR_ZERO : USR_W1;
        USR_ZERO: usr_next = USR_ZERO;
        default: usr_next = USR_W1;
      endcase
    end
  end

  // output words: pattern at the chosen point, data elsewhere
  always_comb begin
    sample_next = sample_in;
    symbol_next = symbol_in;
    octet_next = octet_in;
    if (active && inj == INJ_SAMPLE) begin
      sample_next = tick ? pat_word : sample_reg;
    end
    if (active && inj == INJ_SYMBOL) begin
      symbol_next = tick ? pat_word[9:0] : symbol_reg;
    end
    if (active && inj == INJ_OCTET) begin
      octet_next = tick ? pat_word[7:0] : octet_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave next state
  always_comb begin
    aw_hs = s_axi_awvalid && !aw_full_reg && !bvalid_reg;
    w_hs = s_axi_wvalid && !w_full_reg && !bvalid_reg;
    ar_hs = s_axi_arvalid && !rvalid_reg;
    ar_idx = s_axi_araddr[IDX_LSB +: 14];
    aw_full_next = aw_full_reg || aw_hs;
    aw_idx_next = aw_hs ? s_axi_awaddr[IDX_LSB +: 14] : aw_idx_reg;
    w_full_next = w_full_reg || w_hs;
    w_byte_next = w_hs ? s_axi_wdata[7:0] : w_byte_reg;
    w_lane_next = w_hs ? s_axi_wstrb[0] : w_lane_reg;
    do_write = aw_full_next && w_full_next && !bvalid_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    for (int i = 0; i < 8; i++) begin
      user_byte_next[i] = user_byte_reg[i];
    end
    link_ctrl_next = link_ctrl_reg;
    pat_ctrl_next = pat_ctrl_reg;
    layer_ctrl_next = layer_ctrl_reg;
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      // store through byte lane zero only
      if (aw_idx_next >= IDX_USER_FIRST && aw_idx_next <= IDX_USER_LAST) begin
        if (w_lane_next) begin
          user_byte_next[3'(aw_idx_next - IDX_USER_FIRST)] = w_byte_next;
        end
      end else if (aw_idx_next == IDX_LINK_CTRL) begin
        if (w_lane_next) begin
          link_ctrl_next = w_byte_next;
        end
      end else if (aw_idx_next == IDX_PAT_CTRL) begin
        if (w_lane_next) begin
          pat_ctrl_next = w_byte_next;
        end
      end else if (aw_idx_next == IDX_LAYER_CTRL) begin
        if (w_lane_next) begin
          layer_ctrl_next = w_byte_next;
        end
      end else if (aw_idx_next != IDX_STATUS) begin
        bresp_next = RESP_SLVERR;
      end
    end
    // read data registered with the request
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_hs) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h00000000;
      if (ar_idx >= IDX_USER_FIRST && ar_idx <= IDX_USER_LAST) begin
        rdata_next[7:0] = user_byte_reg[3'(ar_idx - IDX_USER_FIRST)];
      end else if (ar_idx == IDX_LINK_CTRL) begin
        rdata_next[7:0] = link_ctrl_reg;
      end else if (ar_idx == IDX_PAT_CTRL) begin
        rdata_next[7:0] = pat_ctrl_reg;
      end else if (ar_idx == IDX_LAYER_CTRL) begin
        rdata_next[7:0] = layer_ctrl_reg;
      end else if (ar_idx == IDX_STATUS) begin
        rdata_next[15:0] = pat_word; // live pattern word
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // all registers, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        user_byte_reg[i] <= REG_RESET;
      end
      link_ctrl_reg <= REG_RESET;
      pat_ctrl_reg <= REG_RESET;
      layer_ctrl_reg <= REG_RESET;
      aw_full_reg <= 1'b0;
      aw_idx_reg <= 14'h0000;
      w_full_reg <= 1'b0;
      w_byte_reg <= REG_RESET;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
      mode_prev_reg <= MODE_OFF;
      inj_prev_reg <= INJ_SAMPLE;
      lfsr_reg <= SEED_PN7;
      ramp_reg <= WORD_ZERO;
      phase_reg <= 1'b0;
      usr_reg <= USR_W1;
      sample_reg <= WORD_ZERO;
      symbol_reg <= 10'h000;
      octet_reg <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        user_byte_reg[i] <= user_byte_next[i];
      end
      link_ctrl_reg <= link_ctrl_next;
      pat_ctrl_reg <= pat_ctrl_next;
      layer_ctrl_reg <= layer_ctrl_next;
      aw_full_reg <= aw_full_next;
      aw_idx_reg <= aw_idx_next;
      w_full_reg <= w_full_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      mode_prev_reg <= mode_prev_next;
      inj_prev_reg <= inj_prev_next;
      lfsr_reg <= lfsr_next;
      ramp_reg <= ramp_next;
      phase_reg <= phase_next;
      usr_reg <= usr_next;
      sample_reg <= sample_next;
      symbol_reg <= symbol_next;
      octet_reg <= octet_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs; ready held low while ce freezes the slave
  always_comb begin
    s_axi_awready = ce && !aw_full_reg && !bvalid_reg;
    s_axi_wready = ce && !w_full_reg && !bvalid_reg;
    s_axi_arready = ce && !rvalid_reg;
    s_axi_bvalid = bvalid_reg;
    s_axi_bresp = bresp_reg;
    s_axi_rvalid = rvalid_reg;
    s_axi_rdata = rdata_reg;
    s_axi_rresp = rresp_reg;
    sample_out = sample_reg;
    symbol_out = symbol_reg;
    octet_out = octet_reg;
    test_active = active;
    link_layer_test_mode = layer_ctrl_reg[LAYER_LSB +: 3];
    sync_pair_disable = link_ctrl_reg[SYNC_LSB +: 2];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  off_passes_data_a: assert property (@(posedge clk) disable iff (rst)
    ce && mode == MODE_OFF && $past(ce) |=> sample_out == $past(sample_in))
    else $error("data not passed through with test off");
  octet_inject_a: assert property (@(posedge clk) disable iff (rst)
    ce && active && inj == INJ_OCTET && octet_tick |=> octet_out == $past(pat_word[7:0]))
    else $error("octet output not the pattern word");
  pn31_seed_a: assert property (@(posedge clk) disable iff (rst)
    ce && restart && mode == MODE_PN31 |=> lfsr_reg == SEED_PN31)
    else $error("31-bit generator not seeded");
  pn23_seed_a: assert property (@(posedge clk) disable iff (rst)
    ce && restart && mode == MODE_PN23 |=> lfsr_reg == SEED_PN23)
    else $error("23-bit generator not seeded");
  ramp_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && active && mode == MODE_RAMP && tick && !restart
    |=> ramp_reg == (($past(ramp_reg) + RAMP_STEP) & width_mask(width)))
    else $error("ramp did not step by one");
  user_repeat_a: assert property (@(posedge clk) disable iff (rst)
    ce && active && mode == MODE_USER_REPEAT && tick && !restart && usr_reg == USR_W4
    |=> usr_reg == USR_W1)
    else $error("repeat user pattern did not wrap");
  user_single_a: assert property (@(posedge clk) disable iff (rst)
    mode == MODE_USER_SINGLE && usr_reg == USR_ZERO |-> pat_word == WORD_ZERO)
    else $error("single user pattern not zero after four words");
  frame_hold_a: assert property (@(posedge clk) disable iff (rst)
    ce && active && inj == INJ_SAMPLE && !frame_tick |=> $stable(sample_out))
    else $error("sample word changed within a frame");
  symbol_checker_a: assert property (@(posedge clk) disable iff (rst)
    active && inj == INJ_SYMBOL && mode == MODE_CHECKER
    |-> pat_word == 16'h0155 || pat_word == 16'h02AA)
    else $error("symbol checkerboard word wrong");
  restart_clean_a: assert property (@(posedge clk) disable iff (rst)
    ce && restart |=> ramp_reg == WORD_ZERO && usr_reg == USR_W1)
    else $error("pattern state not restarted");

endmodule
`default_nettype wire

// File: ltpg_pkg.sv
// shared constants for the link test pattern generator
package ltpg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_USER_FIRST = 14'h0551; // first user pattern byte
  localparam logic [13:0] IDX_USER_LAST = 14'h0558; // last user pattern byte
  localparam logic [13:0] IDX_LINK_CTRL = 14'h0572; // link control
  localparam logic [13:0] IDX_PAT_CTRL = 14'h0573; // link test pattern control
  localparam logic [13:0] IDX_LAYER_CTRL = 14'h0574; // link layer test control
  localparam logic [13:0] IDX_STATUS = 14'h05F0; // current pattern word, read only
  localparam int ADDR_W = 16; // axi address width
  localparam int IDX_LSB = 2; // word index starts at address bit 2

  ////////////////////////////////////////////////////////////////////////////////
  // field layout
  localparam int MODE_LSB = 0; // pattern code bits [3:0]
  localparam int INJ_LSB = 4; // injection point bits [5:4]
  localparam int LAYER_LSB = 0; // link layer test bits [2:0]
  localparam int SYNC_LSB = 6; // sync disable bits [7:6]
  localparam logic [7:0] REG_RESET = 8'h00; // reset value of every byte register

  ////////////////////////////////////////////////////////////////////////////////
  // pattern codes and injection points
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_CHECKER = 4'b0001,
    MODE_TOGGLE = 4'b0010,
    MODE_PN31 = 4'b0011,
    MODE_PN23 = 4'b0100,
    MODE_PN15 = 4'b0101,
    MODE_PN9 = 4'b0110,
    MODE_PN7 = 4'b0111,
    MODE_RAMP = 4'b1000,
    MODE_USER_REPEAT = 4'b1110,
    MODE_USER_SINGLE = 4'b1111
  } ltpg_mode_e;

  typedef enum logic [1:0] {
    INJ_SAMPLE = 2'b00,
    INJ_SYMBOL = 2'b01,
    INJ_OCTET = 2'b10,
    INJ_NONE = 2'b11
  } ltpg_inj_e;

  // user pattern sequencer
  typedef enum logic [2:0] {
    USR_W1 = 3'b000,
    USR_W2 = 3'b001,
    USR_W3 = 3'b010,
    USR_W4 = 3'b011,
    USR_ZERO = 3'b100
  } ltpg_user_e;

  ////////////////////////////////////////////////////////////////////////////////
  // generator seeds, lengths and taps
  localparam logic [30:0] SEED_PN31 = 31'h0003AFFF;
  localparam logic [30:0] SEED_PN23 = 31'h00003AFF;
  localparam logic [30:0] SEED_PN15 = 31'h000003AF;
  localparam logic [30:0] SEED_PN9 = 31'h00000092;
  localparam logic [30:0] SEED_PN7 = 31'h00000007;
  localparam logic [4:0] LEN_PN31 = 5'h1F;
  localparam logic [4:0] TAP_PN31 = 5'h1C;
  localparam logic [4:0] LEN_PN23 = 5'h17;
  localparam logic [4:0] TAP_PN23 = 5'h12;
  localparam logic [4:0] LEN_PN15 = 5'h0F;
  localparam logic [4:0] TAP_PN15 = 5'h0E;
  localparam logic [4:0] LEN_PN9 = 5'h09;
  localparam logic [4:0] TAP_PN9 = 5'h05;
  localparam logic [4:0] LEN_PN7 = 5'h07;
  localparam logic [4:0] TAP_PN7 = 5'h06;

  ////////////////////////////////////////////////////////////////////////////////
  // word widths and fixed words
  localparam logic [4:0] WIDTH_SAMPLE = 5'h10;
  localparam logic [4:0] WIDTH_SYMBOL = 5'h0A;
  localparam logic [4:0] WIDTH_OCTET = 5'h08;
  localparam logic [15:0] CHECKER_EVEN = 16'h5555;
  localparam logic [15:0] CHECKER_ODD = 16'hAAAA;
  localparam logic [15:0] TOGGLE_EVEN = 16'h0000;
  localparam logic [15:0] TOGGLE_ODD = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] RAMP_STEP = 16'h0001;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: ltpg_prbs_step.sv
`timescale 1ns/1ps
`default_nettype none
// advances a fibonacci generator by one word of width bits, first bit lands in the word msb
module ltpg_prbs_step
  import ltpg_pkg::*;
(
  input wire logic [30:0] state_in,
  input wire logic [4:0] len,
  input wire logic [4:0] tap,
  input wire logic [4:0] width,
  output logic [30:0] state_out,
  output logic [15:0] word
);

  ////////////////////////////////////////////////////////////////////////////////
  // serial unroll: register bit 0 leaves first, so the seed goes out lsb first;
  // feedback enters the top bit of the generator length
  always_comb begin
    logic [30:0] s;
    logic [31:0] keep;
    logic fb;
    s = state_in;
    keep = (32'h00000001 << len) - 32'h00000001;
    fb = 1'b0;
    word = WORD_ZERO;
    for (int i = 0; i < 16; i++) begin
      // only as many bits as the word is wide
      if (5'(i) < width) begin
        fb = s[0] ^ s[len - tap];
        word = {word[14:0], s[0]};
        s = (s >> 1) | (31'(fb) << (len - 5'h01));
      end
    end
    // drop bits shifted above the generator length
    state_out = s & keep[30:0];
  end

endmodule
`default_nettype wire

// File: ltpg_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side receiver: takes the word of a lane one cycle after its tick
module ltpg_rx_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] tick,
  input wire logic [15:0] sample,
  input wire logic [9:0] symbol,
  input wire logic [7:0] octet,
  output logic [15:0] word_reg
);
  logic [2:0] tick_reg; // lane that handed over a word last cycle
  logic [15:0] word_next; // next captured word
  // capture the settled word of the lane that just ticked
  always_comb begin
    word_next = word_reg;
    if (tick_reg[0]) word_next = sample;
    if (tick_reg[1]) word_next = {6'h00, symbol};
    if (tick_reg[2]) word_next = {8'h00, octet};
  end
  // registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reg <= 3'h0;
      word_reg <= 16'h0000;
    end else begin
      tick_reg <= tick;
      word_reg <= word_next;
    end
  end
endmodule
`default_nettype wire

// File: link_test_pattern_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module link_test_pattern_gen_tb_top import ltpg_pkg::*;;
  typedef struct {logic [7:0] c; logic [15:0] e [5];} ltpg_row_s;
  logic clk = 0, rst = 1;
  logic [15:0] awa = 0, ara = 0, si = 0, so, w;
  logic [31:0] wd = 0, rd;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wrd, bv, arr, rv, ta;
  logic [1:0] bre, rre, spd;
  logic [2:0] tk = 0, lm;
  logic [9:0] yi = 0, yo;
  logic [7:0] oi = 0, oo;
  int num_errors = 0, tests_run = 0;
  ltpg_row_s rows [9]; // control byte beside the five words it should give
  always #12.5 clk = ~clk;
  ltpg_core dut (.clk(clk), .rst(rst), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .frame_tick(tk[0]),
    .symbol_tick(tk[1]), .octet_tick(tk[2]), .sample_in(si), .symbol_in(yi), .octet_in(oi),
    .sample_out(so), .symbol_out(yo), .octet_out(oo), .test_active(ta),
    .link_layer_test_mode(lm), .sync_pair_disable(spd));
  ltpg_rx_model rx (.clk(clk), .rst(rst), .tick(tk), .sample(so), .symbol(yo), .octet(oo),
    .word_reg(w));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("wrong value %s exp %h got %h", n, e, s);
      num_errors++;
    end
  endtask
  // axi write: readiness sampled at the falling edge, moves at the next rising edge
  task wr(input logic [13:0] i, input logic [7:0] d, output logic [1:0] r);
    logic a, b, c;
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    br <= 1;
    c = 0;
    while (!c) begin
      @(negedge clk);
      a = awv && awr;
      b = wv && wrd;
      c = bv;
      r = bre;
      @(posedge clk);
      if (a) awv <= 0;
      if (b) wv <= 0;
    end
    br <= 0;
  endtask
  task rdr(input logic [13:0] i, output logic [31:0] d, output logic [1:0] r);
    logic a, c;
    @(posedge clk);
    ara <= {i, 2'b00};
    arv <= 1;
    rr <= 1;
    c = 0;
    while (!c) begin
      @(negedge clk);
      a = arv && arr;
      c = rv;
      d = rd;
      r = rre;
      @(posedge clk);
      if (a) arv <= 0;
    end
    rr <= 0;
  endtask
  // one tick on lane j, word read back from the receiver
  task get(input logic [1:0] j, output logic [15:0] v);
    @(posedge clk);
    tk[j] <= 1;
    @(posedge clk);
    tk <= 0;
    @(posedge clk);
    #1 v = w;
  endtask
  // generator model: bit 0 out, feedback into the top bit
  function automatic logic [15:0] pn(inout logic [30:0] s, input int l, t, n);
    logic b;
    pn = 0;
    for (int i = 0; i < n; i++) begin
      b = s[0] ^ s[l-t];
      pn = {pn[14:0], s[0]};
      s = (s >> 1) | (31'(b) << (l - 1));
    end
  endfunction
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [15:0] v;
    logic [30:0] s;
    rows = '{'{8'h01, '{16'h5555, 16'hAAAA, 16'h5555, 16'hAAAA, 16'h5555}},
      '{8'h11, '{16'h0155, 16'h02AA, 16'h0155, 16'h02AA, 16'h0155}},
      '{8'h22, '{16'h0000, 16'h00FF, 16'h0000, 16'h00FF, 16'h0000}},
      '{8'h14, '{16'h03FD, 16'h01C0, 16'h000A, 16'h01B8, 16'h0028}},
      '{8'h06, '{16'h496F, 16'hC9A9, 16'h980C, 16'h651A, 16'h5FD1}},
      '{8'h28, '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004}},
      '{8'h0E, '{16'h2211, 16'h4433, 16'h6655, 16'h8877, 16'h2211}},
      '{8'h2F, '{16'h0022, 16'h0044, 16'h0066, 16'h0088, 16'h0000}},
      '{8'h1E, '{16'h0088, 16'h0110, 16'h0199, 16'h0221, 16'h0088}}};
    repeat (4) @(posedge clk);
    rst <= 0;
    rdr(IDX_PAT_CTRL, d, r);
    chk("ctrl reset", {24'h0, REG_RESET}, d);
    wr(IDX_LINK_CTRL, 8'hC0, r);
    chk("sync off", 2'b11, spd);
    wr(IDX_LAYER_CTRL, 8'h05, r);
    rdr(IDX_LAYER_CTRL, d, r);
    chk("layer reg", 32'h5, d);
    chk("layer mode", 3'h5, lm);
    wr(IDX_LAYER_CTRL, 8'h00, r);
    wr(14'h0000, 8'h81, r);
    chk("soft reset resp", RESP_SLVERR, r);
    rdr(14'h0000, d, r);
    chk("unmapped resp", RESP_SLVERR, r);
    for (int k = 1; k < 9; k++) wr(14'h0550 + 14'(k), 8'(k * 17), r);
    for (int n = 0; n < 9; n++) begin
      wr(IDX_PAT_CTRL, rows[n].c, r);
      for (int k = 0; k < 5; k++) begin
        get(rows[n].c[5:4], v);
        chk("word", rows[n].e[k], v);
      end
      $display("row %0d done", n);
    end
    // remaining generators against the model, each freshly selected
    for (int n = 0; n < 3; n++) begin
      s = n == 0 ? SEED_PN31 : n == 1 ? SEED_PN15 : SEED_PN7;
      wr(IDX_PAT_CTRL, n == 0 ? 8'h03 : n == 1 ? 8'h25 : 8'h17, r);
      for (int k = 0; k < 4; k++) begin
        get(n == 0 ? 2'd0 : n == 1 ? 2'd2 : 2'd1, v);
        chk("pn", pn(s, n == 0 ? 31 : n == 1 ? 15 : 7, n == 0 ? 28 : n == 1 ? 14 : 6,
          n == 0 ? 16 : n == 1 ? 8 : 10), v);
      end
    end
    $display("generators done");
    // ramp at the octet point wraps after 256 words
    wr(IDX_PAT_CTRL, 8'h00, r);
    wr(IDX_PAT_CTRL, 8'h28, r);
    repeat (256) get(2'd2, v);
    chk("ramp top", 16'h00FF, v);
    get(2'd2, v);
    chk("ramp wrap", 16'h0000, v);
    // injection 11 passes data through
    @(posedge clk);
    oi <= 8'h3C;
    si <= 16'h1234;
    wr(IDX_PAT_CTRL, 8'h31, r);
    @(negedge clk);
    chk("inactive", 1'b0, ta);
    chk("pass", 8'h3C, oo);
    chk("pass sample", 16'h1234, so);
    // reset in mid-run clears the registers
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    rdr(IDX_PAT_CTRL, d, r);
    chk("ctrl after reset", 32'h0, d);
    chk("sync after reset", 2'b00, spd);
    $display("hand tests done");
    finish_test;
  end
endmodule
`default_nettype wire
